// ### logic/dpt_top.v
// Dual prescaled down timer with Avalon-MM register slave.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
// Functional notes
// - 8-bit counter fed by 7-bit prescaler
// - Counter decrements on tap edge; software access
// - Zero sets flag; enabled flag raises request
// - Pending request doubles as wake event
// - Prescaler uses clock/12; timer 1 may use pin
// - Tap: factor 1 input, factor 2 bit 0
// - Run clear forces prescaler ones, counter held
// - Prescaler loadable 0..7Fh while running
// - Tap field encodes power-of-two ratio
// - Gated mode counts only while pin high
// - Event mode counts pin rising edges
// - Output mode latches level on flag rise
// - Writing 00h or bit 7 sets flag
// - Reset: counter FFh, prescaler 7Fh, control 0
// - Counter write beats zero decrement
// - Counter and prescaler readable anytime, each in its own access; no snapshot
// - Control bit layout fixed
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.vh"
module dpt_top
(
	input wire core_clk,
	input wire resetn,
	input wire [`DPT_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire timer_pin_in,
	output reg timer_pin_out,
	output reg timer_pin_oe,
	output reg timer1_irq,
	output reg timer2_irq,
	output reg wake_event
);
	// Divide-by-12 prescaler input strobe
	reg [3:0] div_cnt;
	reg div_tick;
	reg pin_prev;
	wire pin_sync;
	wire [7:0] psc1_raw;
	wire [7:0] psc2_raw;
	wire [6:0] psc1;
	wire [6:0] psc2;
	wire [7:0] cnt1;
	wire [7:0] cnt2;
	wire [7:0] ctl1;
	wire [7:0] ctl2;
	wire zero_rise1;
	wire zero_rise2;
	wire [7:0] idx = avs_address[`DPT_ADDR_W-1:2];
	wire wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire rd = avs_read & ~avs_waitrequest;
	wire tick1;
	reg [7:0] next_rdata;

	dpt_sync u_sync
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in(timer_pin_in),
		.sync_out(pin_sync)
	);

	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			div_cnt <= 4'h0;
			div_tick <= 1'b0;
			pin_prev <= 1'b0;
		end
		else
		begin
			div_cnt <= (div_cnt == `DPT_DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
			div_tick <= (div_cnt == `DPT_DIV_LAST);
			pin_prev <= pin_sync;
		end
	end

	// Timer 1 clock source select by direction and level bits
	assign tick1 = ctl1[`DPT_CTL_DIR] ? div_tick :
		(ctl1[`DPT_CTL_LVL] ? (div_tick & pin_sync) :
		(pin_sync & ~pin_prev));

	dpt_channel u_ch1
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.tick_in(tick1),
		.wr_psc(wr & (idx == `DPT_IDX_PSC1)),
		.wr_cnt(wr & (idx == `DPT_IDX_CNT1)),
		.wr_ctl(wr & (idx == `DPT_IDX_CTL1)),
		.wdata(avs_writedata[7:0]),
		.prescaler_value(psc1),
		.down_counter_value(cnt1),
		.timer_control_status(ctl1),
		.zero_rise(zero_rise1)
	);

	dpt_channel u_ch2
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.tick_in(div_tick),
		.wr_psc(wr & (idx == `DPT_IDX_PSC2)),
		.wr_cnt(wr & (idx == `DPT_IDX_CNT2)),
		.wr_ctl(wr & (idx == `DPT_IDX_CTL2)),
		.wdata(avs_writedata[7:0]),
		.prescaler_value(psc2),
		.down_counter_value(cnt2),
		.timer_control_status(ctl2),
		.zero_rise(zero_rise2)
	);

	assign psc1_raw = {1'b0, psc1};
	assign psc2_raw = {1'b0, psc2};

	// Read mux; prescaler bit 7 reads zero, unmapped reads zero
	always @*
	begin
		case (idx)
			`DPT_IDX_PSC1: next_rdata = psc1_raw;
			`DPT_IDX_CNT1: next_rdata = cnt1;
			`DPT_IDX_CTL1: next_rdata = ctl1;
			`DPT_IDX_PSC2: next_rdata = psc2_raw;
			`DPT_IDX_CNT2: next_rdata = cnt2;
			`DPT_IDX_CTL2: next_rdata = ctl2;
			default: next_rdata = 8'h00;
		endcase
	end

	// One wait state per access so read data come from a flop
	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			timer_pin_out <= 1'b0;
			timer_pin_oe <= 1'b0;
			timer1_irq <= 1'b0;
			timer2_irq <= 1'b0;
			wake_event <= 1'b0;
		end
		else
		begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if ((avs_read | avs_write) & avs_waitrequest)
				avs_readdata <= avs_read ? {24'h00_0000, next_rdata} : 32'h0000_0000;
			else if (rd)
				avs_readdata <= avs_readdata;
			timer_pin_oe <= ctl1[`DPT_CTL_DIR];
			if (ctl1[`DPT_CTL_DIR] & zero_rise1)
				timer_pin_out <= ctl1[`DPT_CTL_LVL];
			timer1_irq <= ctl1[`DPT_CTL_ZERO] & ctl1[`DPT_CTL_IEN];
			timer2_irq <= ctl2[`DPT_CTL_ZERO] & ctl2[`DPT_CTL_IEN];
			wake_event <= (ctl1[`DPT_CTL_ZERO] & ctl1[`DPT_CTL_IEN]) |
				(ctl2[`DPT_CTL_ZERO] & ctl2[`DPT_CTL_IEN]);
		end
	end
endmodule
`default_nettype wire

// ### logic/dpt_regs.vh
// Register map and constants of the dual prescaled down timer.
// Assumes byte-wide registers, one per aligned 32-bit Avalon word.
`ifndef DPT_REGS_VH
`define DPT_REGS_VH

// Register indices (byte address = 4 * index)
`define DPT_IDX_PSC1 8'hD2
`define DPT_IDX_CNT1 8'hD3
`define DPT_IDX_CTL1 8'hD4
`define DPT_IDX_PSC2 8'hD5
`define DPT_IDX_CNT2 8'hD6
`define DPT_IDX_CTL2 8'hD7
`define DPT_ADDR_W 10

// Control register fields
`define DPT_CTL_ZERO 7
`define DPT_CTL_IEN 6
`define DPT_CTL_DIR 5
`define DPT_CTL_LVL 4
`define DPT_CTL_RUN 3
`define DPT_CTL_TAP_HI 2
`define DPT_CTL_TAP_LO 0

// Reset values and counter zero compare value
`define DPT_CNT_RST 8'hFF
`define DPT_PSC_RST 7'h7F
`define DPT_CTL_RST 8'h00
`define DPT_CNT_ZERO 8'h00

// Internal clock divide ratio feeding the prescalers
`define DPT_DIV_RATIO 4'hC
`define DPT_DIV_LAST 4'hB

`endif

// ### logic/dpt_sync.v
// Two-flop synchroniser for the external timer pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module dpt_sync
(
	input wire core_clk,
	input wire resetn,
	input wire async_in,
	output reg sync_out
);
	reg meta;

	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// ### logic/dpt_channel.v
// One timer channel: 7-bit prescaler, tap mux, 8-bit down-counter, control.
// Assumes write strobes are single-cycle and tick_in is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.vh"
module dpt_channel
(
	input wire core_clk,
	input wire resetn,
	input wire tick_in,
	input wire wr_psc,
	input wire wr_cnt,
	input wire wr_ctl,
	input wire [7:0] wdata,
	output reg [6:0] prescaler_value,
	output reg [7:0] down_counter_value,
	output reg [7:0] timer_control_status,
	output reg zero_rise
);
	wire prescaler_run = timer_control_status[`DPT_CTL_RUN];
	wire [2:0] tap = timer_control_status[`DPT_CTL_TAP_HI:`DPT_CTL_TAP_LO];
	wire [6:0] psc_dec = prescaler_value - 7'h01;
	// Bit rising on decrement: tap bit goes 0 -> 1
	wire [6:0] bit_rise = psc_dec & ~prescaler_value;
	wire cnt_tick = tick_in & prescaler_run & ((tap == 3'h0) ? 1'b1 : bit_rise[tap - 3'h1]);
	wire [7:0] cnt_dec = down_counter_value - 8'h01;
	wire hit_zero = cnt_tick & (cnt_dec == `DPT_CNT_ZERO) & ~wr_cnt;
	wire sw_zero = (wr_cnt & (wdata == `DPT_CNT_ZERO)) | (wr_ctl & wdata[`DPT_CTL_ZERO]);
	reg [7:0] next_ctl;

	always @*
	begin
		next_ctl = wr_ctl ? wdata : timer_control_status;
		// Hardware set wins over a software clear
		if (hit_zero | sw_zero)
			next_ctl[`DPT_CTL_ZERO] = 1'b1;
	end

	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			prescaler_value <= `DPT_PSC_RST;
			down_counter_value <= `DPT_CNT_RST;
			timer_control_status <= `DPT_CTL_RST;
			zero_rise <= 1'b0;
		end
		else
		begin
			timer_control_status <= next_ctl;
			zero_rise <= next_ctl[`DPT_CTL_ZERO] & ~timer_control_status[`DPT_CTL_ZERO];
			if (!prescaler_run)
				prescaler_value <= `DPT_PSC_RST;
			else if (wr_psc)
				prescaler_value <= wdata[6:0];
			else if (tick_in)
				prescaler_value <= psc_dec;
			if (wr_cnt)
				down_counter_value <= wdata;
			else if (cnt_tick)
				down_counter_value <= cnt_dec;
		end
	end
endmodule
`default_nettype wire

// ### verification/dpt_top_properties.sv
// Port-level checks for dpt_top.
// Bound to dpt_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dpt_checker
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic timer_pin_out,
	input wire logic timer_pin_oe,
	input wire logic timer1_irq,
	input wire logic timer2_irq,
	input wire logic wake_event
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_ws1; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
	a_ws1: assert property (p_ws1) else $error("wait low too long");
	property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_rdh; $changed(avs_readdata) |-> !avs_waitrequest; endproperty
	a_rdh: assert property (p_rdh) else $error("read data moved");
	property p_wk; (timer1_irq || timer2_irq) |-> ##[0:1] wake_event; endproperty
	a_wk: assert property (p_wk) else $error("no wake");
	property p_wks; wake_event |-> timer1_irq || timer2_irq || $past(timer1_irq || timer2_irq); endproperty
	a_wks: assert property (p_wks) else $error("stray wake");
	property p_oe; $changed(timer_pin_oe) |-> $past(avs_write && !avs_waitrequest) ||
		$past(avs_write && !avs_waitrequest, 2); endproperty
	a_oe: assert property (p_oe) else $error("oe moved alone");
	property p_pin; $changed(timer_pin_out) |-> timer_pin_oe; endproperty
	a_pin: assert property (p_pin) else $error("pin moved in input mode");
endmodule
bind dpt_top dpt_checker u_chk(.core_clk, .resetn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.timer_pin_out, .timer_pin_oe, .timer1_irq, .timer2_irq, .wake_event);
`default_nettype wire

// ### verification/dpt_pin_src.sv
// Signal source and load on the timer pin.
// The timer's own drive wins while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module dpt_pin_src
(
	input wire logic src_level,
	input wire logic timer_pin_oe,
	input wire logic timer_pin_out,
	output wire logic pin
);
	assign pin = timer_pin_oe ? timer_pin_out : src_level;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for dpt_top.
// Drives the Avalon slave and the timer pin source.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk, resetn, avs_read, avs_write, src_level;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [7:0] rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, timer_pin_out, timer_pin_oe, timer1_irq, timer2_irq, wake_event, pin;
	int miscompares = 0;
	int checks = 0;
	dpt_top u_dpt_top(.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_pin_in(pin), .timer_pin_out,
		.timer_pin_oe, .timer1_irq, .timer2_irq, .wake_event);
	dpt_pin_src u_dpt_pin_src(.src_level, .timer_pin_oe, .timer_pin_out, .pin);
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge core_clk);
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_write <= 0;
		avs_read <= 0;
		@(posedge core_clk);
	endtask
	task pulse;
		src_level <= 1;
		repeat (6) @(posedge core_clk);
		src_level <= 0;
		repeat (6) @(posedge core_clk);
	endtask
	task final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		final_report();
	end
	initial
	begin
		resetn = 0;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		avs_byteenable = 4'hF;
		src_level = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		acc(0, 8'hD2, 0); chk("psc1", rd, 8'h7F);
		acc(0, 8'hD3, 0); chk("cnt1", rd, 8'hFF);
		acc(0, 8'hD4, 0); chk("ctl1", rd, 8'h00);
		acc(0, 8'hD5, 0); chk("psc2", rd, 8'h7F);
		acc(0, 8'hD6, 0); chk("cnt2", rd, 8'hFF);
		acc(0, 8'hD7, 0); chk("ctl2", rd, 8'h00);
		acc(0, 8'h10, 0); chk("unmapped", rd, 8'h00);
		avs_byteenable <= 4'h0;
		acc(1, 8'hD6, 8'h00);
		avs_byteenable <= 4'hF;
		acc(0, 8'hD6, 0); chk("cnt2 be", rd, 8'hFF);
		acc(1, 8'hD6, 8'h00);
		acc(0, 8'hD7, 0); chk("zero by write", rd, 8'h80);
		acc(1, 8'hD4, 8'h80);
		acc(0, 8'hD4, 0); chk("zero by bit7", rd, 8'h80);
		$display("test reset and flags done");
		acc(1, 8'hD6, 8'h02);
		acc(1, 8'hD7, 8'h48);
		for (int k = 0; k < 100 && timer2_irq !== 1'b1; k++) @(posedge core_clk);
		chk("irq2", {7'h0, timer2_irq}, 8'h01);
		chk("wake", {7'h0, wake_event}, 8'h01);
		acc(0, 8'hD6, 0); chk("cnt2 zero", rd, 8'h00);
		acc(0, 8'hD7, 0); chk("ctl2 flag", rd, 8'hC8);
		acc(1, 8'hD7, 8'h00);
		repeat (2) @(posedge core_clk);
		chk("irq2 off", {7'h0, timer2_irq}, 8'h00);
		acc(1, 8'hD5, 8'h10);
		acc(0, 8'hD5, 0); chk("psc2 held", rd, 8'h7F);
		// Factor 2: counter steps on every second prescaler tick
		acc(1, 8'hD6, 8'h01);
		acc(1, 8'hD7, 8'h49);
		for (int k = 0; k < 100 && timer2_irq !== 1'b1; k++) @(posedge core_clk);
		chk("irq2 tap1", {7'h0, timer2_irq}, 8'h01);
		acc(0, 8'hD5, 0); chk("psc2 tap1", rd, 8'h7D);
		acc(0, 8'hD6, 0); chk("cnt2 tap1", rd, 8'h00);
		$display("test timer2 done");
		acc(1, 8'hD4, 8'h48);
		acc(1, 8'hD2, 8'h05);
		acc(0, 8'hD2, 0); chk("psc1 load", rd, 8'h05);
		acc(1, 8'hD3, 8'h02);
		pulse();
		chk("irq1 early", {7'h0, timer1_irq}, 8'h00);
		pulse();
		chk("irq1", {7'h0, timer1_irq}, 8'h01);
		acc(0, 8'hD2, 0); chk("psc1 events", rd, 8'h03);
		acc(1, 8'hD4, 8'h58);
		acc(1, 8'hD3, 8'h05);
		repeat (60) @(posedge core_clk);
		acc(0, 8'hD3, 0); chk("gated low", rd, 8'h05);
		src_level <= 1;
		for (int k = 0; k < 200 && timer1_irq !== 1'b1; k++) @(posedge core_clk);
		chk("gated high", {7'h0, timer1_irq}, 8'h01);
		src_level <= 0;
		$display("test timer1 input done");
		acc(1, 8'hD4, 8'h30);
		// Enable is registered one cycle after the control write
		@(posedge core_clk);
		chk("oe", {7'h0, timer_pin_oe}, 8'h01);
		chk("pin idle", {7'h0, timer_pin_out}, 8'h00);
		acc(1, 8'hD4, 8'hB0);
		repeat (3) @(posedge core_clk);
		chk("pin high", {7'h0, timer_pin_out}, 8'h01);
		acc(1, 8'hD4, 8'h20);
		acc(1, 8'hD4, 8'hA0);
		repeat (3) @(posedge core_clk);
		chk("pin low", {7'h0, timer_pin_out}, 8'h00);
		$display("test output done");
		final_report();
	end
endmodule
`default_nettype wire
